/* sfs_flash_front.sv */
`timescale 1ns/1ps
// How it works
// R1 - chip select high: idle, input ignored, output off
// R2 - works with clock idling low or high
// R3 - sample on rising edge, drive on falling
// R4 - byte addresses, 4K sectors, 32K/64K blocks
// R5 - page program keeps one to 256 bytes
// R6 - busy flag reads one during operations
// R7 - latch clear blocks every write operation
// R8 - latch set and clear commands move latch
// R9 - master sets latch before each write
// R10 - latch clears when an operation completes
// R11 - protected region rejects program and erase
// R12 - array erase needs all protect bits zero
// R13 - lock bit with protect pin low freezes status
// R14 - quad enable removes protect and pause functions
// R15 - pause freezes the sequence without aborting
// R16 - protect and lock bits change only by write
// R17 - status read returns status register
// R18 - status bit order lock, quad, protect, latch, busy
// R19 - opcode byte first, msb first, then address, data
// R20 - chip select rise ends every command
// R21 - write commands need whole bytes
// R22 - status read answered while busy
module sfs_flash_front #(
   parameter int OP_BUSY = sfs_pkg::OP_BUSY_CYCLES
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_CS_N,
   input wire logic I_SCK,
   input wire logic I_SI,
   input wire logic I_WP_N,
   input wire logic I_HOLD_N,
   output logic O_SO,
   output logic O_SO_OE,
   output logic O_ARR_PROG,
   output logic O_ARR_ERASE,
   output logic [1:0] O_ARR_ERASE_SIZE,
   output logic [sfs_pkg::ADDR_W-1:0] O_ARR_ADDR,
   output logic [7:0] O_ARR_DATA
);
   localparam int AW = sfs_pkg::ADDR_W;

   typedef enum logic [2:0] {PH_OPC = 3'b001, PH_ADDR = 3'b010, PH_DATA = 3'b100} sfs_phase_t;
   typedef enum logic [2:0] {EN_IDLE = 3'b001, EN_DRAIN = 3'b010, EN_WAIT = 3'b100} sfs_eng_t;

   function automatic logic prot_hit(input logic [AW-1:0] a, input logic [3:0] bp);
      logic [7:0] blk;
      logic [7:0] first;
      blk = {1'b0, a[AW-1:sfs_pkg::BLK64_LSB]};
      first = sfs_pkg::BLOCKS_ALL - (8'h01 << (bp[2:0] - 3'h1));
      if (bp == 4'h0) begin
         prot_hit = 1'b0;
      end else if (bp[3]) begin
         prot_hit = 1'b1;
      end else begin
         prot_hit = (blk >= first);
      end
   endfunction

   function automatic logic has_addr(input logic [7:0] op);
      has_addr = (op == sfs_pkg::OPC_PAGE_PROGRAM) || (op == sfs_pkg::OPC_SECTOR_ERASE) ||
                 (op == sfs_pkg::OPC_BLK32_ERASE) || (op == sfs_pkg::OPC_BLK64_ERASE);
   endfunction

   // pin synchronisers
   logic [1:0] cs_sy_r, sck_sy_r, si_sy_r, wp_sy_r, hold_sy_r;
   logic sck_d_r, cs_d_r;
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         cs_sy_r <= 2'h3;
         sck_sy_r <= 2'h0;
         si_sy_r <= 2'h0;
         wp_sy_r <= 2'h3;
         hold_sy_r <= 2'h3;
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         cs_sy_r <= {cs_sy_r[0], I_CS_N};
         sck_sy_r <= {sck_sy_r[0], I_SCK};
         si_sy_r <= {si_sy_r[0], I_SI};
         wp_sy_r <= {wp_sy_r[0], I_WP_N};
         hold_sy_r <= {hold_sy_r[0], I_HOLD_N};
         sck_d_r <= sck_sy_r[1];
         cs_d_r <= cs_sy_r[1];
      end
   end

   sfs_phase_t ph_r;
   sfs_eng_t eng_r;
   logic [7:0] shift_r, opc_r, first_r, wr_idx_r, so_sr_r;
   logic [2:0] bit_r, so_bit_r;
   logic [1:0] abyte_r;
   logic [AW-1:0] addr_r;
   logic [8:0] dcnt_r, cnt_r, k_r;
   logic [5:0] nv_r;
   logic wel_r, opc_ok_r, rd_act_r, so_r, so_oe_r;
   logic [15:0] wait_r;
   logic [7:0] start_r;
   logic [AW-9:0] page_r;
   logic prog_v_r, erase_r;
   logic [1:0] er_size_r;
   logic [AW-1:0] arr_addr_r;
   logic [7:0] idx_d_r;
   sfs_buf_if buf_if ();

   wire cs_n = cs_sy_r[1];
   wire sck = sck_sy_r[1];
   wire si = si_sy_r[1];
   wire qe = nv_r[sfs_pkg::SR_QE - sfs_pkg::SR_BP_LSB];
   wire lock = nv_r[sfs_pkg::SR_LOCK - sfs_pkg::SR_BP_LSB];
   wire [3:0] bp = nv_r[3:0];
   wire hold_act = ~qe & ~hold_sy_r[1]; // R14 R15
   wire wp_low = ~qe & ~wp_sy_r[1]; // R14
   wire locked = lock & wp_low; // R13
   wire cs_rise = cs_n & ~cs_d_r; // R20
   // edges count only while selected, so either idle clock level works
   wire take_rise = ~cs_n & sck & ~sck_d_r & ~hold_act; // R1 R2 R3 R15
   wire take_fall = ~cs_n & ~sck & sck_d_r & ~hold_act; // R2 R3
   wire [7:0] byte_in = {shift_r[6:0], si}; // R19
   wire byte_done = take_rise & (bit_r == sfs_pkg::BIT_LAST);
   wire busy = (eng_r != EN_IDLE); // R6
   wire [7:0] status = {nv_r, wel_r, busy}; // R18
   wire is_erase = has_addr(opc_r) && (opc_r != sfs_pkg::OPC_PAGE_PROGRAM);
   wire is_all_erase = (opc_r == sfs_pkg::OPC_ARRAY_ERASE);
   wire cmd_ok = cs_rise & opc_ok_r & (bit_r == 3'h0) & ~busy; // R21 R22
   wire write_ok = cmd_ok & wel_r & (ph_r == PH_DATA); // R7 R9
   wire ex_latch_set_cmd = cmd_ok & (opc_r == sfs_pkg::OPC_LATCH_SET); // R8
   wire ex_latch_clear_cmd = cmd_ok & (opc_r == sfs_pkg::OPC_LATCH_CLEAR); // R8
   wire ex_status_write_cmd = write_ok & (opc_r == sfs_pkg::OPC_STATUS_WRITE) & (dcnt_r != 9'h0) & ~locked; // R13 R16
   wire ex_pp = write_ok & (opc_r == sfs_pkg::OPC_PAGE_PROGRAM) & (dcnt_r != 9'h0) &
                ~prot_hit(addr_r, bp); // R5 R11
   wire ex_er = write_ok & (is_erase | is_all_erase) & (dcnt_r == 9'h0) &
                (is_all_erase ? (bp == 4'h0) : ~prot_hit(addr_r, bp)); // R11 R12
   wire op_start = ex_status_write_cmd | ex_pp | ex_er;
   wire drain_last = (eng_r == EN_DRAIN) & (k_r == cnt_r - 9'h1);
   wire wait_done = (eng_r == EN_WAIT) & (wait_r == 16'(OP_BUSY - 1));
   wire [1:0] er_size = is_all_erase ? sfs_pkg::ER_ALL :
                        (opc_r == sfs_pkg::OPC_SECTOR_ERASE) ? sfs_pkg::ER_SECTOR :
                        (opc_r == sfs_pkg::OPC_BLK32_ERASE) ? sfs_pkg::ER_BLK32 : sfs_pkg::ER_BLK64;
   wire [AW-1:0] er_mask = is_all_erase ? {AW{1'b0}} :
                           (opc_r == sfs_pkg::OPC_SECTOR_ERASE) ? ({AW{1'b1}} << sfs_pkg::SECTOR_LSB) :
                           (opc_r == sfs_pkg::OPC_BLK32_ERASE) ? ({AW{1'b1}} << sfs_pkg::BLK32_LSB) :
                           ({AW{1'b1}} << sfs_pkg::BLK64_LSB); // R4

   // serial input: opcode, address, data
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ph_r <= PH_OPC;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         opc_r <= 8'h00;
         opc_ok_r <= 1'b0;
         abyte_r <= 2'h0;
      end else if (cs_n) begin
         ph_r <= PH_OPC; // R1
         bit_r <= 3'h0;
         opc_ok_r <= 1'b0;
         abyte_r <= 2'h0;
      end else if (take_rise) begin
         shift_r <= byte_in;
         bit_r <= bit_r + 3'h1;
         if (byte_done) begin
            unique case (ph_r)
               PH_OPC: begin
                  opc_r <= byte_in;
                  opc_ok_r <= 1'b1;
                  ph_r <= has_addr(byte_in) ? PH_ADDR : PH_DATA; // R19
               end
               PH_ADDR: begin
                  abyte_r <= abyte_r + 2'h1;
                  if (abyte_r == sfs_pkg::ADDR_BYTES_LAST) begin
                     ph_r <= PH_DATA;
                  end
               end
               PH_DATA: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         addr_r <= {AW{1'b0}};
         dcnt_r <= 9'h0;
         first_r <= 8'h00;
         wr_idx_r <= 8'h00;
      end else if (cs_rise) begin
         dcnt_r <= 9'h0;
      end else if (byte_done && ph_r == PH_ADDR) begin
         addr_r <= {addr_r[AW-9:0], byte_in}; // R4
         wr_idx_r <= byte_in;
      end else if (byte_done && ph_r == PH_DATA) begin
         if (dcnt_r == 9'h0) begin
            first_r <= byte_in;
         end
         if (dcnt_r != sfs_pkg::PAGE_FULL) begin
            dcnt_r <= dcnt_r + 9'h1; // R5
         end
         if (buf_if.wr_en) begin
            wr_idx_r <= wr_idx_r + 8'h01;
         end
      end
   end

   // page buffer wraps within the page, keeping the last 256 bytes
   assign buf_if.wr_en = byte_done & (ph_r == PH_DATA) & (opc_r == sfs_pkg::OPC_PAGE_PROGRAM) & ~busy; // R5
   assign buf_if.wr_idx = wr_idx_r;
   assign buf_if.wr_data = byte_in;
   assign buf_if.rd_en = (eng_r == EN_DRAIN);
   assign buf_if.rd_idx = start_r + k_r[7:0];

   sfs_page_buf #(.DEPTH(sfs_pkg::PAGE_BYTES)) u_buf (
      .i_clk(I_CLOCK),
      .bus(buf_if.mem)
   );

   // status register: latch and non-volatile bits
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wel_r <= 1'b0;
         nv_r <= sfs_pkg::NV_RESET; // R16
      end else begin
         if (ex_latch_set_cmd) begin
            wel_r <= 1'b1; // R8
         end else if (ex_latch_clear_cmd || wait_done) begin
            wel_r <= 1'b0; // R8 R10
         end
         if (ex_status_write_cmd) begin
            nv_r <= first_r[7:2]; // R13 R16
         end
      end
   end

   // operation engine: drain page, then hold busy
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         eng_r <= EN_IDLE;
         k_r <= 9'h0;
         cnt_r <= 9'h0;
         wait_r <= 16'h0;
         start_r <= 8'h00;
         page_r <= '0;
      end else begin
         unique case (eng_r)
            EN_IDLE: begin
               k_r <= 9'h0;
               wait_r <= 16'h0;
               if (ex_pp) begin
                  eng_r <= EN_DRAIN; // R6
                  cnt_r <= dcnt_r;
                  start_r <= wr_idx_r - dcnt_r[7:0];
                  page_r <= addr_r[AW-1:8];
               end else if (op_start) begin
                  eng_r <= EN_WAIT; // R6
               end
            end
            EN_DRAIN: begin
               k_r <= k_r + 9'h1;
               if (drain_last) begin
                  eng_r <= EN_WAIT;
               end
            end
            EN_WAIT: begin
               wait_r <= wait_r + 16'h1;
               if (wait_done) begin
                  eng_r <= EN_IDLE; // R10
               end
            end
         endcase
      end
   end

   // array strobes
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         prog_v_r <= 1'b0;
         erase_r <= 1'b0;
         er_size_r <= 2'h0;
         arr_addr_r <= {AW{1'b0}};
         idx_d_r <= 8'h00;
      end else begin
         prog_v_r <= buf_if.rd_en;
         idx_d_r <= buf_if.rd_idx;
         erase_r <= ex_er;
         if (ex_er) begin
            er_size_r <= er_size;
            arr_addr_r <= addr_r & er_mask; // R4
         end else if (prog_v_r) begin
            arr_addr_r <= {page_r, idx_d_r};
         end
      end
   end

   assign O_ARR_PROG = prog_v_r;
   assign O_ARR_DATA = buf_if.rd_data;
   assign O_ARR_ERASE = erase_r;
   assign O_ARR_ERASE_SIZE = er_size_r;
   assign O_ARR_ADDR = prog_v_r ? {page_r, idx_d_r} : arr_addr_r;

   // status read output, shifted on falling edges
   always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rd_act_r <= 1'b0;
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
         so_bit_r <= 3'h0;
         so_sr_r <= 8'h00;
      end else if (cs_n) begin
         rd_act_r <= 1'b0;
         so_oe_r <= 1'b0; // R1
         so_bit_r <= 3'h0;
      end else if (byte_done && ph_r == PH_OPC) begin
         rd_act_r <= (byte_in == sfs_pkg::OPC_STATUS_READ); // R17 R22
      end else if (take_fall && rd_act_r) begin
         so_oe_r <= 1'b1;
         so_bit_r <= so_bit_r + 3'h1;
         if (so_bit_r == 3'h0) begin
            so_r <= status[7]; // R17
            so_sr_r <= {status[6:0], 1'b0};
         end else begin
            so_r <= so_sr_r[7]; // R3
            so_sr_r <= {so_sr_r[6:0], 1'b0};
         end
      end
   end

   assign O_SO = so_r;
   assign O_SO_OE = so_oe_r & ~cs_n & ~hold_act; // R1 R15

   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_ARST_N);

   sequence s_opc_done;
      byte_done && ph_r == PH_OPC;
   endsequence
   sequence s_op_run;
      busy [*2];
   endsequence

   a_deselect_no_drive: assert property (cs_n |=> !so_oe_r && !rd_act_r) // R1
      else $error("serial output driven while deselected");
   a_start_sets_busy: assert property (op_start |=> s_op_run) // R6
      else $error("busy not raised after operation start");
   a_start_needs_latch: assert property ($rose(busy) |-> wel_r && $past(bit_r) == 3'h0) // R7
      else $error("operation started without latch or whole bytes");
   a_latch_set_cmd: assert property (ex_latch_set_cmd |=> wel_r) // R8
      else $error("latch not set by latch set command");
   a_latch_auto_clear: assert property ($fell(busy) |-> !wel_r) // R10
      else $error("latch still set after operation end");
   a_protect_blocks_prog: assert property ((O_ARR_PROG || (O_ARR_ERASE && O_ARR_ERASE_SIZE != 2'h3)) // R11
      |-> !prot_hit(O_ARR_ADDR, bp))
      else $error("program started in protected region");
   a_array_erase_bp: assert property (O_ARR_ERASE && O_ARR_ERASE_SIZE == 2'h3 |-> // R12
      bp == 4'h0 && $past(ex_er && is_all_erase))
      else $error("array erase with protect bits set");
   a_lock_freezes: assert property (locked && !busy |=> $stable(nv_r)) // R13
      else $error("status changed while locked");
   a_pause_freezes: assert property (hold_act && !cs_n |=> $stable(bit_r) && $stable(so_bit_r)) // R15
      else $error("sequence moved during pause");
   a_read_while_busy: assert property (busy ##0 s_opc_done ##0 (byte_in == sfs_pkg::OPC_STATUS_READ) // R22
      |=> rd_act_r)
      else $error("status read not accepted");
   a_drain_count: assert property ($rose(busy) && prog_v_r == 1'b0 ##1 prog_v_r |-> $past(cnt_r) != 9'h0) // R5
      else $error("program with no data");
endmodule // sfs_flash_front

/* sfs_pkg.sv */
package sfs_pkg;
   localparam int ADDR_W = 23;
   localparam logic [22:0] ADDR_TOP = 23'h7fffff;
   localparam int PAGE_BYTES = 256;
   localparam int SECTOR_LSB = 12;
   localparam int BLK32_LSB = 15;
   localparam int BLK64_LSB = 16;
   localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] BLOCKS_ALL = 8'h80;
   localparam logic [8:0] PAGE_FULL = 9'h100;
   // opcode values are fixed package localparams
   localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ = 8'h05;
   localparam logic [7:0] OPC_LATCH_SET = 8'h06;
   localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OPC_BLK32_ERASE = 8'h52;
   localparam logic [7:0] OPC_BLK64_ERASE = 8'hd8;
   localparam logic [7:0] OPC_ARRAY_ERASE = 8'hc7;
   // status register bit positions
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP_LSB = 2;
   localparam int SR_QE = 6;
   localparam int SR_LOCK = 7;
   localparam logic [5:0] NV_RESET = 6'h00;
   localparam int OP_BUSY_CYCLES = 64;
   typedef enum logic [1:0] {
      ER_SECTOR = 2'h0,
      ER_BLK32 = 2'h1,
      ER_BLK64 = 2'h2,
      ER_ALL = 2'h3
   } sfs_erase_t;
endpackage

/* sfs_buf_if.sv */
`timescale 1ns/1ps
interface sfs_buf_if;
   logic wr_en;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic rd_en;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;
   modport ctl (output wr_en, output wr_idx, output wr_data, output rd_en, output rd_idx, input rd_data);
   modport mem (input wr_en, input wr_idx, input wr_data, input rd_en, input rd_idx, output rd_data);
endinterface // sfs_buf_if

/* sfs_page_buf.sv */
`timescale 1ns/1ps
module sfs_page_buf #(
   parameter int DEPTH = sfs_pkg::PAGE_BYTES
) (
   input wire logic i_clk,
   sfs_buf_if.mem bus
);
   logic [7:0] mem_r [DEPTH];
   logic [7:0] rd_data_r;

   always_ff @(posedge i_clk) begin
      if (bus.wr_en) begin
         mem_r[bus.wr_idx] <= bus.wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (bus.rd_en) begin
         rd_data_r <= mem_r[bus.rd_idx];
      end
   end

   assign bus.rd_data = rd_data_r;
endmodule // sfs_page_buf

/* sfs_spi_master.sv */
`timescale 1ns/1ps
module sfs_spi_master (
   input wire logic i_clk,
   input wire logic i_so,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   output logic o_hold_n
);
   localparam realtime H = 62.5;
   bit mode3 = 0;
   initial begin
      o_cs_n = 1;
      o_sck = 0;
      o_si = 0;
      o_hold_n = 1;
   end
   // desel clocks a frame with select left high, which the device must ignore
   task automatic frame(input logic [7:0] b[$], input int tail, input int hold_at, input bit desel,
                        output logic [7:0] rx);
      int n;
      n = b.size() * 8 + tail;
      rx = 8'h00;
      @(negedge i_clk);
      #1.25;
      o_sck = mode3;
      // clock reaches its idle level before select falls, so no false edge
      #H;
      o_cs_n = desel;
      #H;
      for (int i = 0; i < n; i++) begin
         if (i == hold_at) begin
            o_sck = 0;
            #H;
            o_hold_n = 0;
            repeat (3) begin
               #H;
               o_sck = 1;
               o_si = ~o_si;
               #H;
               o_sck = 0;
            end
            #H;
            o_hold_n = 1;
            #H;
         end
         o_sck = 0;
         o_si = (i < b.size() * 8) ? b[i / 8][7 - i % 8] : 1'b1;
         #H;
         o_sck = 1;
         rx = {rx[6:0], i_so};
         #H;
      end
      o_sck = mode3;
      #H;
      o_cs_n = 1;
      o_si = ~o_si;  // a released line must not keep its last value
      #(4 * H);
   endtask
endmodule // sfs_spi_master

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) chk(40'(g), 40'(e))
module testbench;
   localparam int OPB = 400;
   logic clk = 0;
   logic arst_n = 0;
   logic wp_n = 1;
   logic so_hold = 0;
   wire cs_n;
   wire sck;
   wire si;
   wire hold_n;
   wire so_line;
   logic so;
   logic so_oe;
   logic prog;
   logic erase;
   logic [1:0] esize;
   logic [22:0] addr;
   logic [7:0] data;
   int mismatches = 0;
   int tests_run = 0;
   int cs_cnt = 0;
   logic m_lock = 0;
   logic m_qe = 0;
   logic [3:0] m_bp = 0;
   logic m_wel = 0;
   logic [39:0] expq[$];
   logic [7:0] ecodes[4] = '{sfs_pkg::OPC_SECTOR_ERASE, sfs_pkg::OPC_BLK32_ERASE,
                             sfs_pkg::OPC_BLK64_ERASE, sfs_pkg::OPC_ARRAY_ERASE};
   int lsbs[4] = '{sfs_pkg::SECTOR_LSB, sfs_pkg::BLK32_LSB, sfs_pkg::BLK64_LSB, 0};

   sfs_flash_front #(.OP_BUSY(OPB)) i_dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_CS_N(cs_n), .I_SCK(sck),
      .I_SI(si), .I_WP_N(wp_n), .I_HOLD_N(hold_n), .O_SO(so), .O_SO_OE(so_oe), .O_ARR_PROG(prog),
      .O_ARR_ERASE(erase), .O_ARR_ERASE_SIZE(esize), .O_ARR_ADDR(addr), .O_ARR_DATA(data));
   sfs_spi_master i_mst (.i_clk(clk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
      .o_hold_n(hold_n));

   always #2.5 clk = ~clk;
   always @(posedge clk) if (so_oe) so_hold <= so;
   assign so_line = so_oe ? so : ~so_hold;

   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic end_sim();
      $display("counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [39:0] mk(input logic p, input logic e, input logic [1:0] s,
                                      input logic [22:0] a, input logic [7:0] d);
      return {5'h0, p, e, e ? s : 2'h0, (e && s == 2'h3) ? 23'h0 : a, p ? d : 8'h0};
   endfunction

   function automatic logic [7:0] msr(input logic busy);
      return {m_lock, m_qe, m_bp, m_wel, busy};
   endfunction

   function automatic bit prot(input logic [22:0] a);
      if (m_bp == 4'h0) return 0;
      if (m_bp >= 4'h8) return 1;
      return int'(a[22:16]) >= 128 - (1 << (int'(m_bp) - 1));
   endfunction

   always @(negedge clk) begin
      cs_cnt <= cs_n ? cs_cnt + 1 : 0;
      if (cs_cnt > 8) `CHK(so_oe, 0);
      if (prog | erase) `CHK(mk(prog, erase, esize, addr, data), expq.size() > 0 ? expq.pop_front() : 40'h0);
   end

   task automatic sr_read(output logic [7:0] v);
      i_mst.frame('{sfs_pkg::OPC_STATUS_READ, 8'h00}, 0, -1, 0, v);
   endtask

   task automatic latch(input bit set, input int hold_at);
      logic [7:0] v;
      i_mst.frame('{set ? sfs_pkg::OPC_LATCH_SET : sfs_pkg::OPC_LATCH_CLEAR}, 0, hold_at, 0, v);
      m_wel = set;
      sr_read(v);
      `CHK(v, msr(0));
   endtask

   // one write-type command; the model decides whether it takes effect
   task automatic op(input logic [7:0] b[$], input int tail, input bit wen);
      logic [7:0] v;
      logic [22:0] a;
      int k;
      bit ok;
      if (wen) latch(1, -1);
      a = b.size() > 3 ? {b[1][6:0], b[2], b[3]} : 23'h0;
      k = -1;
      for (int i = 0; i < 4; i++) if (b[0] == ecodes[i]) k = i;
      ok = m_wel && tail == 0;
      if (b[0] == sfs_pkg::OPC_STATUS_WRITE) ok = ok && !(m_lock && !wp_n && !m_qe);
      if (b[0] == sfs_pkg::OPC_PAGE_PROGRAM || (k >= 0 && k < 3)) ok = ok && !prot(a);
      if (k == 3) ok = ok && m_bp == 4'h0;
      if (ok && b[0] == sfs_pkg::OPC_PAGE_PROGRAM)
         for (int i = 4; i < b.size(); i++) expq.push_back(mk(1, 0, 0, {a[22:8], 8'(a[7:0] + i - 4)}, b[i]));
      if (ok && k >= 0) expq.push_back(mk(0, 1, 2'(k), a & ~((23'h1 << lsbs[k]) - 23'h1), 0));
      if (ok && b[0] == sfs_pkg::OPC_STATUS_WRITE) {m_lock, m_qe, m_bp} = b[1][7:2];
      i_mst.frame(b, tail, -1, 0, v);
      sr_read(v);
      `CHK(v, msr(ok));
      if (ok) begin
         m_wel = 0;
         for (int i = 0; i < 20 && v[0] === 1'b1; i++) sr_read(v);
         if (v[0] !== 1'b0) begin
            mismatches++;
            end_sim();
         end
      end
      `CHK(v, msr(0));
      `CHK(expq.size(), 0);
   endtask

   initial begin
      logic [7:0] v;
      logic [22:0] a;
      logic [7:0] wvals[4];
      wvals = '{8'h80, 8'h3c, 8'hc0, 8'h00};
      void'($urandom(32'h869ce034));
      repeat (16) @(negedge clk);
      arst_n = 1;
      repeat (4) @(negedge clk);
      sr_read(v);
      `CHK(v, 8'h00);
      i_mst.frame('{sfs_pkg::OPC_LATCH_SET}, 0, -1, 1, v);
      sr_read(v);
      `CHK(v, 8'h00);
      $display("test reset and deselect done");
      op('{sfs_pkg::OPC_STATUS_WRITE, 8'h3c}, 0, 0);
      i_mst.mode3 = 1;
      latch(1, 4);
      latch(0, -1);
      op('{sfs_pkg::OPC_STATUS_WRITE, 8'h3c}, 7, 1);
      i_mst.mode3 = 0;
      $display("test latch, pause and partial byte done");
      op('{sfs_pkg::OPC_STATUS_WRITE, {2'h0, 4'(1 + $urandom % 7), 2'h0}}, 0, 1);
      for (int j = 0; j < 2; j++) begin
         a = {j ? 7'h7f : 7'($urandom % 64), 8'($urandom), 8'hfe};
         op('{sfs_pkg::OPC_PAGE_PROGRAM, {1'b0, a[22:16]}, a[15:8], a[7:0], 8'($urandom), 8'($urandom),
              8'($urandom)}, 0, 1);
      end
      for (int k = 0; k < 4; k++) begin
         a = {1'b0, 22'($urandom)};
         if (k < 3) op('{ecodes[k], {1'b0, a[22:16]}, a[15:8], a[7:0]}, 0, 1);
         else op('{ecodes[3]}, 0, 1);
      end
      op('{sfs_pkg::OPC_STATUS_WRITE, 8'h00}, 0, 1);
      op('{ecodes[3]}, 0, 1);
      $display("test program and erase done");
      for (int j = 0; j < 4; j++) begin
         @(negedge clk);
         wp_n = ~j[0];
         op('{sfs_pkg::OPC_STATUS_WRITE, wvals[j]}, 0, 1);
      end
      $display("test status lock done");
      end_sim();
   end
endmodule // testbench
